// >>> hw/adc_link_pkg.sv
package adc_link_pkg;

  localparam int RESULT_W = 24;

  // Modulator runs at clk / 6 with oversampling 64
  localparam int MOD_DIV = 6;
  localparam int OSR = 64;

  // Times are in system clock periods, hold counts in conversion cycles; clk is the system clock (50 MHz here)
  localparam int CYCLE_CLKS = MOD_DIV * OSR;
  localparam int WRITE_CLKS = 6;
  localparam int LOW_CLKS = 6;
  localparam int HIGH_CLKS = 6;
  localparam int PRE_READY_CLKS = 24;
  localparam int READY_CLKS = WRITE_CLKS + LOW_CLKS + PRE_READY_CLKS;
  localparam int OUTPUT_CLKS = CYCLE_CLKS - READY_CLKS;
  localparam int SYNC_LOW_CLKS = 3;
  localparam int SYNC_HOLD_CYCLES = 4;
  localparam int PDOWN_HOLD_CYCLES = 20;

  // Release delays as printed, in half clock periods, rounded up to whole clocks
  localparam int SYNC_RELEASE_HALF_CLKS = 4085;
  localparam int WAKE_HALF_CLKS = 4637;
  localparam int SYNC_RELEASE_CLKS = (SYNC_RELEASE_HALF_CLKS + 1) / 2;
  localparam int WAKE_CLKS = (WAKE_HALF_CLKS + 1) / 2;
  localparam int POWERUP_CLKS = SYNC_RELEASE_CLKS;

  localparam int POS_W = 9;
  localparam int WAIT_W = 12;
  localparam logic [POS_W-1:0] POS_LOW = POS_W'(WRITE_CLKS);
  localparam logic [POS_W-1:0] POS_HIGH = POS_W'(WRITE_CLKS + LOW_CLKS);
  localparam logic [POS_W-1:0] POS_DATA = POS_W'(WRITE_CLKS + LOW_CLKS + HIGH_CLKS);
  localparam logic [POS_W-1:0] POS_PRE = POS_W'(CYCLE_CLKS - PRE_READY_CLKS);
  localparam logic [POS_W-1:0] POS_LAST = POS_W'(CYCLE_CLKS - 1);
  // Wait loads so that the low pulse starts the given delay after the detected fall
  localparam logic [WAIT_W-1:0] WAIT_SYNC = WAIT_W'(SYNC_RELEASE_CLKS - WRITE_CLKS - 2);
  localparam logic [WAIT_W-1:0] WAIT_WAKE = WAIT_W'(WAKE_CLKS - WRITE_CLKS - 2);
  localparam logic [WAIT_W-1:0] WAIT_POWERUP = WAIT_W'(POWERUP_CLKS - WRITE_CLKS - 2);

  // Host shift clock shape and ready-pulse recognition
  // Both three-stage lags plus the pin update take eight clocks; nine is the fewest that samples the new bit
  localparam int SCLK_LOW_CLKS = 9;
  localparam int SCLK_HIGH_CLKS = 4;
  localparam int RUN_MIN_CLKS = 20;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_RUN = 2'b01,
    ST_SYNC = 2'b10,
    ST_PDOWN = 2'b11
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_ARMED = 2'b01,
    H_SHIFT = 2'b10
  } host_state_t;

endpackage

// >>> hw/adc_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface adc_link_if;
  logic sclk;
  logic ready_and_serial_out_pin;

  modport device (
    input sclk,
    output ready_and_serial_out_pin
  );

  modport host (
    output sclk,
    input ready_and_serial_out_pin
  );
endinterface

`default_nettype wire

// >>> hw/adc_readout_device.sv
// What this block and the host on the link do
// R01: First ready pulse only once data valid.
// R02: Pin alternates ready indication and serial output.
// R03: Cycle 384 clocks: ready 36, output 348.
// R04: High 6 writing, low 6, high 6.
// R05: Negative result keeps pin high after that.
// R06: Host clocks only after ready mode ends.
// R07: Bit changes on fall; host samples rise.
// R08: Host reads whole word before ready mode.
// R09: Pin high 24 clocks before ready mode.
// R10: No clocks: most significant bit stays shown.
// R11: Short read: last shown bit stays.
// R12: Over 24 clocks: pin stays low.
// R13: Bit pointer reset at write and pre-ready.
// R14: 24-bit two's complement, sent MSB first.
// R15: Four high cycles: 3-clock low, modulator reset.
// R16: Host holds high four to under twenty cycles.
// R17: Host holds five cycles for several devices.
// R18: Falling edge releases; ready pulse 2042.5 later.
// R19: Sync 1537 to 7679 clocks after rise.
// R20: Twenty high cycles enter power-down.
// R21: Power-down no earlier than 7681 clocks.
// R22: Falling edge wakes; ready pulse 2318.5 later.
// R23: Clock divided by 6, ratio 64.
`timescale 1ns/1ps
`default_nettype none

module adc_readout_device #(
  parameter int RES_W = adc_link_pkg::RESULT_W
) (
  input wire logic clk,
  input wire logic srst,
  adc_link_if.device link,
  input wire logic [RES_W-1:0] res_data,
  input wire logic res_valid,
  output logic res_ready,
  output logic modulator_reset,
  output logic power_down
);

  typedef struct packed {
    adc_link_pkg::dev_state_t st;
    logic [adc_link_pkg::POS_W-1:0] pos;
    logic [adc_link_pkg::WAIT_W-1:0] wait_cnt;
    logic [4:0] ptr;
    logic [RES_W-1:0] result_output_register;
    logic [4:0] hi_cyc;
    logic [1:0] pulse;
    logic [2:0] sy;
    logic sclk_lv;
    logic [1:0][RES_W-1:0] mem;
    logic wr_idx;
    logic rd_idx;
    logic [1:0] cnt;
    logic pin;
  } dev_reg_t;

  dev_reg_t q;
  dev_reg_t d;
  logic fall;
  logic push;
  logic pop;
  logic boundary;
  logic [RES_W-1:0] shifted;

  // Producer stalls here while both entries wait for a conversion slot
  assign res_ready = (q.cnt != 2'h2);
  assign push = res_valid & res_ready;

  always_comb begin
    d = q;
    fall = 1'b0;
    pop = 1'b0;
    boundary = 1'b0;
    shifted = '0;

    // Three-stage sync; level changes once stages two and three agree
    d.sy = {q.sy[1:0], link.sclk};
    if (q.sy[2] == q.sy[1]) begin
      d.sclk_lv = q.sy[2];
    end
    fall = q.sclk_lv & ~d.sclk_lv;

    if (q.st == adc_link_pkg::ST_RUN || q.st == adc_link_pkg::ST_SYNC) begin
      boundary = (q.pos == adc_link_pkg::POS_LAST);
      if (boundary) begin // R03 R23
        d.pos = '0;
      end else begin
        d.pos = q.pos + 1'b1;
      end
    end

    // Cycle boundaries passed with the clock held high are counted, the first one ending a partial cycle
    if (!d.sclk_lv) begin
      d.hi_cyc = '0;
    end else if (boundary && q.hi_cyc != 5'h1F) begin
      d.hi_cyc = q.hi_cyc + 1'b1;
    end

    case (q.st)
      adc_link_pkg::ST_WAIT: begin
        if (q.wait_cnt == '0) begin // R01 R18 R22
          d.st = adc_link_pkg::ST_RUN;
          d.pos = '0;
        end else begin
          d.wait_cnt = q.wait_cnt - 1'b1;
        end
      end
      adc_link_pkg::ST_RUN: begin
        if (d.hi_cyc == 5'(adc_link_pkg::SYNC_HOLD_CYCLES + 1)) begin // R15 R19
          d.st = adc_link_pkg::ST_SYNC;
          d.pulse = 2'(adc_link_pkg::SYNC_LOW_CLKS);
        end else if (fall && q.pos >= adc_link_pkg::POS_DATA
                     && q.pos < adc_link_pkg::POS_PRE && q.ptr != 5'(RES_W)) begin
          d.ptr = q.ptr + 1'b1; // R07 R11 R12
        end
      end
      adc_link_pkg::ST_SYNC: begin
        if (q.pulse != 2'h0) begin
          d.pulse = q.pulse - 1'b1;
        end
        if (fall) begin // R18
          d.st = adc_link_pkg::ST_WAIT;
          d.wait_cnt = adc_link_pkg::WAIT_SYNC;
          d.hi_cyc = '0;
          d.pulse = '0;
        end else if (d.hi_cyc == 5'(adc_link_pkg::PDOWN_HOLD_CYCLES + 1)) begin
          d.st = adc_link_pkg::ST_PDOWN; // R20 R21
        end
      end
      adc_link_pkg::ST_PDOWN: begin
        if (fall) begin // R22
          d.st = adc_link_pkg::ST_WAIT;
          d.wait_cnt = adc_link_pkg::WAIT_WAKE;
          d.hi_cyc = '0;
        end
      end
      default: begin
        d.st = adc_link_pkg::ST_WAIT;
      end
    endcase

    if (d.st == adc_link_pkg::ST_RUN && d.pos == '0) begin
      // Without a fresh word the previous result is shown again
      if (q.cnt != 2'h0) begin
        pop = 1'b1;
        d.result_output_register = q.mem[q.rd_idx];
        d.rd_idx = ~q.rd_idx;
      end
      d.ptr = '0; // R13
    end
    if (d.st == adc_link_pkg::ST_RUN && d.pos == adc_link_pkg::POS_PRE) begin
      d.ptr = '0; // R13
    end

    if (push) begin
      d.mem[q.wr_idx] = res_data;
      d.wr_idx = ~q.wr_idx;
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};

    // Pin follows the next state so pin_q lines up with pos_q
    shifted = d.result_output_register << d.ptr;
    case (d.st)
      adc_link_pkg::ST_RUN: begin
        if (d.pos < adc_link_pkg::POS_LOW) begin
          d.pin = 1'b1; // R04
        end else if (d.pos < adc_link_pkg::POS_HIGH) begin
          d.pin = 1'b0; // R04 R02
        end else if (d.pos < adc_link_pkg::POS_DATA) begin
          d.pin = 1'b1; // R04 R05
        end else if (d.pos < adc_link_pkg::POS_PRE) begin
          // MSB first; past the last bit the pin reads low
          d.pin = (d.ptr < 5'(RES_W)) ? shifted[RES_W-1] : 1'b0; // R10 R11 R12 R14
        end else begin
          d.pin = 1'b1; // R09
        end
      end
      adc_link_pkg::ST_SYNC: begin
        d.pin = (d.pulse == 2'h0); // R15
      end
      default: begin
        d.pin = 1'b1; // R01
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.st <= adc_link_pkg::ST_WAIT;
      q.wait_cnt <= adc_link_pkg::WAIT_POWERUP;
      q.pin <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.ready_and_serial_out_pin = q.pin; // R02
  assign modulator_reset = (q.st == adc_link_pkg::ST_SYNC) | (q.st == adc_link_pkg::ST_PDOWN);
  assign power_down = (q.st == adc_link_pkg::ST_PDOWN);

endmodule

`default_nettype wire

// >>> hw/adc_readout_host.sv
`timescale 1ns/1ps
`default_nettype none

module adc_readout_host #(
  parameter int RES_W = adc_link_pkg::RESULT_W
) (
  input wire logic clk,
  input wire logic srst,
  adc_link_if.host link,
  input wire logic hold_req,
  output logic [RES_W-1:0] word_data,
  output logic word_valid,
  input wire logic word_ready
);

  typedef struct packed {
    adc_link_pkg::host_state_t st;
    logic [2:0] sy;
    logic pin_lv;
    logic [4:0] run;
    logic [3:0] tick;
    logic [4:0] bits;
    logic sclk;
    logic [RES_W-1:0] sh;
    logic [1:0][RES_W-1:0] mem;
    logic wr_idx;
    logic rd_idx;
    logic [1:0] cnt;
  } host_reg_t;

  host_reg_t q;
  host_reg_t d;
  logic rose;
  logic fell;
  logic push;
  logic pop;

  assign pop = word_valid & word_ready;

  always_comb begin
    d = q;
    push = 1'b0;
    d.sy = {q.sy[1:0], link.ready_and_serial_out_pin};
    if (q.sy[2] == q.sy[1]) begin
      d.pin_lv = q.sy[2];
    end
    rose = ~q.pin_lv & d.pin_lv;
    fell = q.pin_lv & ~d.pin_lv;
    if (!d.pin_lv) begin
      d.run = '0;
    end else if (q.run != 5'h1F) begin
      d.run = q.run + 1'b1;
    end

    if (hold_req) begin
      d.sclk = 1'b1; // R16 R17
      d.st = adc_link_pkg::H_IDLE;
    end else begin
      case (q.st)
        adc_link_pkg::H_IDLE: begin
          d.sclk = 1'b0;
          // A long high run ending in a fall is a ready pulse, not a data bit
          if (fell && q.run >= 5'(adc_link_pkg::RUN_MIN_CLKS) && q.cnt != 2'h2) begin
            d.st = adc_link_pkg::H_ARMED;
          end
        end
        adc_link_pkg::H_ARMED: begin
          if (rose) begin // R06
            d.st = adc_link_pkg::H_SHIFT;
            d.tick = '0;
            d.bits = '0;
          end
        end
        adc_link_pkg::H_SHIFT: begin
          d.tick = q.tick + 1'b1;
          if (!q.sclk && q.tick == 4'(adc_link_pkg::SCLK_LOW_CLKS - 1)) begin
            d.sclk = 1'b1;
            d.tick = '0;
            d.sh = {q.sh[RES_W-2:0], q.pin_lv}; // R07 R14
            d.bits = q.bits + 1'b1;
          end else if (q.sclk && q.tick == 4'(adc_link_pkg::SCLK_HIGH_CLKS - 1)) begin
            d.sclk = 1'b0;
            d.tick = '0;
            if (q.bits == 5'(RES_W)) begin // R08
              push = 1'b1;
              // The low after the last bit is no ready pulse
              d.run = '0;
              d.st = adc_link_pkg::H_IDLE;
            end
          end
        end
        default: begin
          d.st = adc_link_pkg::H_IDLE;
        end
      endcase
    end

    if (push) begin
      d.mem[q.wr_idx] = q.sh;
      d.wr_idx = ~q.wr_idx;
    end
    if (pop) begin
      d.rd_idx = ~q.rd_idx;
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.st <= adc_link_pkg::H_IDLE;
    end else begin
      q <= d;
    end
  end

  assign link.sclk = q.sclk;
  assign word_valid = (q.cnt != 2'h0);
  assign word_data = q.mem[q.rd_idx];

endmodule

`default_nettype wire

// >>> tb/adc_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adc_link_properties (
  input wire logic clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic ready_and_serial_out_pin
);
  logic [5:0] pin_hi_q;
  logic [5:0] sclk_lo_q;
  logic [12:0] sclk_hi_q;
  logic [8:0] since_q;
  logic [2:0] pin_lo_q;
  logic pin;
  logic ready_fall;
  logic sync_end;
  logic shift_rise;
  assign pin = ready_and_serial_out_pin;
  // Long high run on a quiet link marks a ready pulse, never a data bit
  assign ready_fall = !pin && pin_hi_q >= 6'h1E && sclk_lo_q >= 6'h14;
  // Short low run ending under a held clock; ready pulses last six, data runs longer
  assign sync_end = pin && pin_lo_q != 3'h0 && pin_lo_q < 3'h6 && sclk && sclk_hi_q > 13'h008;
  assign shift_rise = sclk && sclk_lo_q != 6'h00 && sclk_lo_q <= 6'h0C;
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_hi_q <= 6'h00;
      sclk_lo_q <= 6'h00;
      sclk_hi_q <= 13'h0000;
      since_q <= 9'h000;
      pin_lo_q <= 3'h0;
    end else begin
      pin_lo_q <= pin ? 3'h0 : (pin_lo_q == 3'h7 ? pin_lo_q : pin_lo_q + 3'h1);
      // Clocks since the last ready fall; parks at the top when no pulse follows
      if (ready_fall) begin
        since_q <= 9'h001;
      end else if (since_q != 9'h000 && since_q != 9'h1FF) begin
        since_q <= since_q + 9'h001;
      end
      pin_hi_q <= !pin ? 6'h00 : (pin_hi_q == 6'h3F ? pin_hi_q : pin_hi_q + 6'h01);
      sclk_lo_q <= sclk ? 6'h00 : (sclk_lo_q == 6'h3F ? sclk_lo_q : sclk_lo_q + 6'h01);
      sclk_hi_q <= !sclk ? 13'h0000 : (sclk_hi_q == 13'h1FFF ? sclk_hi_q : sclk_hi_q + 13'h0001);
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_ready_low_six: assert property (ready_fall |-> !pin [*6] ##1 pin)
    else $error("ready low pulse not six clocks");
  a_ready_high_six: assert property (ready_fall |-> ##6 pin [*6])
    else $error("high interval before data not six clocks");
  a_cycle_period: assert property (since_q == 9'h180 |-> !pin)
    else $error("ready pulses not 384 clocks apart");
  a_pre_ready_high: assert property (since_q >= 9'h162 && since_q <= 9'h179 |-> pin)
    else $error("pin not high for 24 clocks before ready");
  a_no_early_shift: assert property ((ready_fall || (since_q != 9'h000 && since_q <= 9'h00B)) |-> !$rose(sclk))
    else $error("shift clock during ready mode");
  a_bit_stable_rise: assert property (shift_rise |-> $stable(pin) [*4])
    else $error("data bit moved around rising shift edge");
  a_sync_window: assert property (sync_end |-> sclk_hi_q >= 13'h0604 && sclk_hi_q <= 13'h1E02)
    else $error("sync pulse outside allowed delay");
  a_sync_pulse_three: assert property (sync_end |-> pin_lo_q == 3'h3)
    else $error("sync low pulse not three clocks");
  a_held_high_sync: assert property (sclk && sclk_hi_q >= 13'h07D0 |-> pin)
    else $error("pin not held high during hold");
endmodule
`default_nettype wire

// >>> tb/adc_serial_readout_sync_powerdown_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout_sync_powerdown_tb;
  typedef struct packed {
    logic [23:0] in;
    logic [23:0] exp;
  } row_t;
  logic clk;
  logic srst;
  logic [23:0] res_data;
  logic res_valid;
  logic res_ready;
  logic modulator_reset;
  logic power_down;
  logic hold_req;
  logic [23:0] word_data;
  logic word_valid;
  logic word_ready;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  row_t rows [5];
  adc_link_if u_adc_link_if ();
  adc_readout_device u_adc_readout_device (.clk(clk), .srst(srst), .link(u_adc_link_if),
    .res_data(res_data), .res_valid(res_valid), .res_ready(res_ready),
    .modulator_reset(modulator_reset), .power_down(power_down));
  adc_readout_host u_adc_readout_host (.clk(clk), .srst(srst), .link(u_adc_link_if),
    .hold_req(hold_req), .word_data(word_data), .word_valid(word_valid),
    .word_ready(word_ready));
  adc_link_properties u_adc_link_properties (.clk(clk), .srst(srst),
    .sclk(u_adc_link_if.sclk),
    .ready_and_serial_out_pin(u_adc_link_if.ready_and_serial_out_pin));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic summarize();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Whole run is about 36000 clocks
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      summarize();
    end
  end
  task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bits(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic push(input logic [23:0] w);
    int k = 0;
    @(negedge clk);
    while (res_ready !== 1'b1 && k < 2000) begin
      k++;
      @(negedge clk);
    end
    res_data = w;
    res_valid = 1'b1;
    @(negedge clk);
    res_valid = 1'b0;
  endtask
  task automatic get(input logic [23:0] exp);
    int k = 0;
    @(negedge clk);
    word_ready = 1'b1;
    while (word_valid !== 1'b1 && k < 2000) begin
      k++;
      @(negedge clk);
    end
    cmp_word(word_data, exp);
    @(negedge clk);
    word_ready = 1'b0;
  endtask
  // Host stalls with two words held, so the device resends the same word meanwhile
  task automatic check_word(input logic [23:0] w, input logic [23:0] exp);
    push(w);
    word_ready = 1'b1;
    ticks(800);
    word_ready = 1'b0;
    ticks(1200);
    get(exp);
    get(exp);
  endtask
  task automatic wait_pin_low();
    n = 0;
    while (u_adc_link_if.ready_and_serial_out_pin !== 1'b0 && n < 3000) begin
      n++;
      @(negedge clk);
    end
  endtask
  task automatic hold_test(input int t1, input int t2, input logic pd, input int rel);
    int k = 0;
    // Hold starts after a whole read, clear of ready mode and of any bit edge
    while (u_adc_link_if.sclk !== 1'b1 && k < 2000) begin
      k++;
      @(negedge clk);
    end
    ticks(340);
    k = 0;
    hold_req = 1'b1;
    while (u_adc_link_if.sclk !== 1'b1 && k < 2000) begin
      k++;
      @(negedge clk);
    end
    ticks(t1);
    cmp_bits({modulator_reset, power_down}, 2'b10);
    ticks(t2 - t1);
    cmp_bits({modulator_reset, power_down}, {1'b1, pd});
    hold_req = 1'b0;
    k = 0;
    while (u_adc_link_if.sclk !== 1'b0 && k < 2000) begin
      k++;
      @(negedge clk);
    end
    wait_pin_low();
    cmp_bits({1'b0, n >= rel && n <= rel + 12}, 2'b01);
  endtask
  initial begin
    res_data = 24'h000000;
    res_valid = 1'b0;
    hold_req = 1'b0;
    word_ready = 1'b0;
    srst = 1'b1;
    rows[0] = row_t'{24'h000000, 24'h000000};
    rows[1] = row_t'{24'h800000, 24'h800000};
    rows[2] = row_t'{24'h7FFFFF, 24'h7FFFFF};
    rows[3] = row_t'{24'hFFFFFF, 24'hFFFFFF};
    rows[4] = row_t'{24'h5A3C96, 24'h5A3C96};
    ticks(8);
    srst = 1'b0;
    wait_pin_low();
    cmp_bits({1'b0, n >= adc_link_pkg::POWERUP_CLKS - 1}, 2'b01);
    for (int i = 0; i < 5; i++) begin
      check_word(rows[i].in, rows[i].exp);
    end
    hold_test(2100, 2200, 1'b0, adc_link_pkg::SYNC_RELEASE_CLKS);
    check_word(24'h123456, 24'h123456);
    hold_test(7670, 8300, 1'b1, adc_link_pkg::WAKE_CLKS);
    check_word(24'hE1D2C3, 24'hE1D2C3);
    srst = 1'b1;
    ticks(8);
    srst = 1'b0;
    @(negedge clk);
    cmp_bits({modulator_reset, power_down}, 2'b00);
    cmp_bits({1'b0, word_valid}, 2'b00);
    ticks(2100);
    check_word(24'h0F0F0F, 24'h0F0F0F);
    summarize();
  end
endmodule
`default_nettype wire
